/* common/e1rx_pkg.sv */
// Package: constants for the E1 receive timeslot conditioning block
`default_nettype none
package e1rx_pkg;
   // Host direct register offsets (host_addr)
   localparam logic [2:0] E1RX_SB_ACC_CTRL = 3'h0;
   localparam logic [2:0] E1RX_SB_ACC_DATA = 3'h1;
   localparam logic [2:0] E1RX_PL_ACC_CTRL = 3'h2;
   localparam logic [2:0] E1RX_PL_ACC_DATA = 3'h3;
   localparam logic [2:0] E1RX_GLOBAL_CFG  = 3'h4;
   // Access control fields
   localparam int E1RX_RNW_BIT = 7;
   // Global config fields
   localparam int E1RX_GAP_EN_BIT = 3;
   localparam int E1RX_GSEL_MSB   = 2;
   // Timeslot control fields
   localparam int E1RX_SUBST_MSB = 7;
   localparam int E1RX_SUBST_LSB = 5;
   localparam int E1RX_MSB_INV   = 4;
   localparam int E1RX_ODD_INV   = 3;
   localparam int E1RX_EVEN_INV  = 2;
   localparam int E1RX_LSB_GAP   = 1;
   localparam int E1RX_FULL_GAP  = 0;
   // Signaling register fields
   localparam int E1RX_EXTRACT_BIT = 4;
   localparam int E1RX_SIGNALING_TRUNK_ENABLE_BIT  = 4;
   localparam int E1RX_TEST_BIT    = 6;
   // Indirect address bases
   localparam logic [6:0] E1RX_IA_DTRK = 7'h20;
   localparam logic [6:0] E1RX_IA_STRK = 7'h40;
   // Reset values
   localparam logic [7:0] E1RX_RST_BYTE = 8'h00;
   // Replacement select codes
   localparam logic [2:0] E1RX_SEL_NONE = 3'h0;
   localparam logic [2:0] E1RX_SEL_DTRK = 3'h1;
   localparam logic [2:0] E1RX_SEL_ALAW = 3'h2;
   localparam logic [2:0] E1RX_SEL_ULAW = 3'h3;
   // Inversion masks, bit 1 of the slot is data[7]
   localparam logic [7:0] E1RX_MASK_MSB  = 8'h80;
   localparam logic [7:0] E1RX_MASK_ODD  = 8'h2A;
   localparam logic [7:0] E1RX_MASK_EVEN = 8'h55;
   // Last timeslot of a frame
   localparam logic [4:0] E1RX_LAST_TS = 5'h1F;
   // Digital milliwatt sequences, one byte per frame
   localparam logic [63:0] E1RX_ALAW_MW = 64'h34_21_21_34_B4_A1_A1_B4;
   localparam logic [63:0] E1RX_ULAW_MW = 64'h1E_0B_0B_1E_9E_8B_8B_9E;

   // Inversion mask from the three select bits
   function automatic logic [7:0] e1rx_inv_mask(input logic [7:0] ctl);
      e1rx_inv_mask = (ctl[E1RX_MSB_INV] ? E1RX_MASK_MSB : 8'h00)
                    | (ctl[E1RX_ODD_INV] ? E1RX_MASK_ODD : 8'h00)
                    | (ctl[E1RX_EVEN_INV] ? E1RX_MASK_EVEN : 8'h00);
   endfunction

   // Voice timeslots carry signaling; 0 and 16 do not
   function automatic logic e1rx_is_voice(input logic [4:0] ts);
      e1rx_is_voice = (ts[3:0] != 4'h0);
   endfunction
endpackage
`default_nettype wire

/* common/e1rx_xf_if.sv */
// Interface: one timeslot byte and its settings into the transform
`timescale 1ns/100ps
`default_nettype none
interface e1rx_xf_if;
   logic [7:0] din;
   logic [7:0] ctl;
   logic [7:0] dtrk;
   logic [2:0] gsel;
   logic [2:0] phase;
   logic [7:0] dout;
   modport src (output din, ctl, dtrk, gsel, phase, input dout);
   modport xf  (input din, ctl, dtrk, gsel, phase, output dout);
endinterface
`default_nettype wire

/* hdl/e1rx_slot_xform.sv */
// Payload replacement and bit inversion for one timeslot byte
`timescale 1ns/100ps
`default_nettype none
module e1rx_slot_xform
   import e1rx_pkg::*;
(
   // Timeslot byte and settings
   e1rx_xf_if.xf xf
);
   logic [2:0] sel;
   logic [7:0] rep;
   logic [7:0] mw_a;
   logic [7:0] mw_u;

   // Global select takes precedence unless it is 000
   assign sel = (xf.gsel == E1RX_SEL_NONE) ?
                xf.ctl[E1RX_SUBST_MSB:E1RX_SUBST_LSB] : xf.gsel; // RULE8

   // Milliwatt byte for this frame phase, first byte in the top lane
   assign mw_a = E1RX_ALAW_MW[8*(7-xf.phase) +: 8];
   assign mw_u = E1RX_ULAW_MW[8*(7-xf.phase) +: 8];

   // Replacement source
   always_comb
   begin
      case (sel)
         E1RX_SEL_NONE: rep = xf.din; // RULE9
         E1RX_SEL_DTRK: rep = xf.dtrk; // RULE9 RULE19
         E1RX_SEL_ALAW: rep = mw_a; // RULE10
         E1RX_SEL_ULAW: rep = mw_u; // RULE10
         default:       rep = xf.din; // RULE22
      endcase
   end

   // Inversion follows replacement, so trunk codes can be inverted too
   assign xf.dout = rep ^ e1rx_inv_mask(xf.ctl); // RULE11 RULE12 RULE13 RULE14 RULE15 RULE16 RULE17
endmodule // e1rx_slot_xform
`default_nettype wire

/* hdl/e1rx_tsc_top.sv */
// E1 receive timeslot conditioning: signaling extract and payload control
//
// What this block does
// RULE1: signaling buffer has one indirect register per voice slot, 01-0F, 11-1F.
// RULE2: extraction happens only while signaling multiframe alignment holds.
// RULE3: extract enable set copies received ABCD into read-only bits 3..0.
// RULE4: extracted nibble is read-only and meaningful only while enabled.
// RULE5: payload control addresses 00-1F are timeslot control for slots 0-31.
// RULE6: payload control addresses 20-3F are data trunk codes for slots 0-31.
// RULE7: addresses 41-4F and 51-5F are signaling trunk codes, slots 1-15, 17-31.
// RULE8: per-slot replace select acts only while global select is 000.
// RULE9: select 000 passes payload, 001 substitutes the data trunk code.
// RULE10: select 010 gives A-law milliwatt, 011 gives mu-law milliwatt.
// RULE11: no select inverts nothing; even select inverts bits 2,4,6,8.
// RULE12: odd select alone inverts bits 3,5,7, MSB untouched.
// RULE13: odd plus even inverts bits 2 through 8.
// RULE14: MSB select alone inverts bit 1.
// RULE15: MSB plus even inverts bits 1,2,4,6,8.
// RULE16: MSB plus odd inverts bits 1,3,5,7.
// RULE17: all three selects invert all eight bits.
// RULE18: gap bits act only in clock master mode with gap enable set.
// RULE19: each data trunk register holds an 8-bit replacement code.
// RULE20: software loads access data before writing address with write flag.
// RULE21: signaling trunk enable replaces signaling bits with the trunk code.
// RULE22: reserved replace codes are not used; device passes payload unchanged.
`timescale 1ns/100ps
`default_nettype none
module e1rx_tsc_top
   import e1rx_pkg::*;
#(
   parameter int NUM_TS = 32
)
(
   // Clock, enable, reset
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic       rst_n,
   // Host register port
   input  wire logic       host_wr,
   input  wire logic       host_rd,
   input  wire logic [2:0] host_addr,
   input  wire logic [7:0] host_wdata,
   output logic [7:0]      host_rdata,
   output logic            host_rvalid,
   // Receive stream from framer
   input  wire logic       ts_valid,
   input  wire logic [4:0] ts_num,
   input  wire logic [7:0] ts_data,
   input  wire logic [3:0] ts_sig,
   input  wire logic       smf_aligned,
   input  wire logic       rx_clk_master,
   // Conditioned stream to backplane
   output logic            out_valid,
   output logic [4:0]      out_ts,
   output logic [7:0]      out_data,
   output logic [3:0]      out_sig,
   output logic            out_gap_lsb,
   output logic            out_gap_full
);
   // Per-slot storage
   logic [7:0] ctl_r     [NUM_TS];
   logic [7:0] dtrk_r    [NUM_TS];
   logic [5:0] strk_r    [NUM_TS];
   logic       sig_en_r  [NUM_TS];
   logic [3:0] sig_nib_r [NUM_TS];

   // Direct registers
   logic [7:0] sb_ctl_r;
   logic [7:0] sb_dat_r;
   logic [7:0] pl_ctl_r;
   logic [7:0] pl_dat_r;
   logic [3:0] gcfg_r;
   logic [2:0] phase_r;

   // Decoded host strobes
   logic       sb_go;
   logic       pl_go;
   logic       rnw;
   logic [6:0] ia;
   logic [4:0] ia_ts;
   logic [7:0] sb_rd_val;
   logic [7:0] pl_rd_val;
   logic [7:0] xf_out;

   // Access control write starts the indirect transfer
   assign sb_go = ce && host_wr && (host_addr == E1RX_SB_ACC_CTRL);
   assign pl_go = ce && host_wr && (host_addr == E1RX_PL_ACC_CTRL);
   assign rnw   = host_wdata[E1RX_RNW_BIT];
   assign ia    = host_wdata[6:0];
   assign ia_ts = host_wdata[4:0];

   // Signaling buffer address check: 01-0F and 11-1F only
   function automatic logic sb_hit(input logic [6:0] a);
      sb_hit = (a[6:5] == 2'b00) && e1rx_is_voice(a[4:0]); // RULE1
   endfunction

   // Signaling trunk address check: 41-4F and 51-5F only
   function automatic logic st_hit(input logic [6:0] a);
      st_hit = (a[6:5] == E1RX_IA_STRK[6:5])
            && e1rx_is_voice(a[4:0]); // RULE7
   endfunction

   // Indirect read value of the signaling buffer; reserved bits read zero
   always_comb
   begin
      sb_rd_val = 8'h00;
      if (sb_hit(ia))
      begin
         sb_rd_val[E1RX_EXTRACT_BIT] = sig_en_r[ia_ts];
         sb_rd_val[3:0]              = sig_nib_r[ia_ts]; // RULE4
      end
   end

   // Indirect read value of payload control; unmapped reads return zero
   always_comb
   begin
      pl_rd_val = 8'h00;
      if (ia[6:5] == 2'b00)
      begin
         pl_rd_val = ctl_r[ia_ts]; // RULE5
      end
      else if (ia[6:5] == E1RX_IA_DTRK[6:5])
      begin
         pl_rd_val = dtrk_r[ia_ts]; // RULE6
      end
      else if (st_hit(ia))
      begin
         pl_rd_val = {1'b0, strk_r[ia_ts][5], 1'b0, strk_r[ia_ts][4:0]};
      end
   end

   // Signaling buffer direct registers; a read op refills the data register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sb_ctl_r <= E1RX_RST_BYTE;
         sb_dat_r <= E1RX_RST_BYTE;
      end
      else if (sb_go)
      begin
         sb_ctl_r <= host_wdata;
         if (rnw)
         begin
            sb_dat_r <= sb_rd_val;
         end
      end
      else if (ce && host_wr && host_addr == E1RX_SB_ACC_DATA)
      begin
         sb_dat_r <= host_wdata;
      end
   end

   // Payload control direct registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pl_ctl_r <= E1RX_RST_BYTE;
         pl_dat_r <= E1RX_RST_BYTE;
      end
      else if (pl_go)
      begin
         pl_ctl_r <= host_wdata;
         if (rnw)
         begin
            pl_dat_r <= pl_rd_val;
         end
      end
      else if (ce && host_wr && host_addr == E1RX_PL_ACC_DATA)
      begin
         pl_dat_r <= host_wdata;
      end
   end

   // Global config: clock gap enable and global replace select
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         gcfg_r <= 4'h0;
      end
      else if (ce && host_wr && host_addr == E1RX_GLOBAL_CFG)
      begin
         gcfg_r <= host_wdata[3:0];
      end
   end

   // Extract enables written from the previously loaded data register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_TS; i++)
         begin
            sig_en_r[i] <= 1'b0;
         end
      end
      else if (sb_go && !rnw && sb_hit(ia))
      begin
         sig_en_r[ia_ts] <= sb_dat_r[E1RX_EXTRACT_BIT]; // RULE1 RULE20
      end
   end

   // Extraction: only aligned, enabled voice slots update the nibble
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_TS; i++)
         begin
            sig_nib_r[i] <= 4'h0;
         end
      end
      else if (ce && ts_valid && e1rx_is_voice(ts_num)
               && smf_aligned && sig_en_r[ts_num]) // RULE2
      begin
         sig_nib_r[ts_num] <= ts_sig; // RULE3
      end
   end

   // Payload control tables; host writes hit only decoded slots
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_TS; i++)
         begin
            ctl_r[i]  <= E1RX_RST_BYTE;
            dtrk_r[i] <= E1RX_RST_BYTE;
            strk_r[i] <= 6'h00;
         end
      end
      else if (pl_go && !rnw) // RULE20
      begin
         if (ia[6:5] == 2'b00)
         begin
            ctl_r[ia_ts] <= pl_dat_r; // RULE5
         end
         else if (ia[6:5] == E1RX_IA_DTRK[6:5])
         begin
            dtrk_r[ia_ts] <= pl_dat_r; // RULE6 RULE19
         end
         else if (st_hit(ia))
         begin
            strk_r[ia_ts] <= {pl_dat_r[E1RX_TEST_BIT], pl_dat_r[4:0]}; // RULE7
         end
      end
   end

   // Frame phase steps the milliwatt sequence once per frame
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase_r <= 3'h0;
      end
      else if (ce && ts_valid && ts_num == E1RX_LAST_TS)
      begin
         phase_r <= phase_r + 3'h1;
      end
   end

   // Transform of the current byte, shared with the pass-through path
   e1rx_xf_if xfi ();
   assign xfi.din   = ts_data;
   assign xfi.ctl   = ctl_r[ts_num];
   assign xfi.dtrk  = dtrk_r[ts_num];
   assign xfi.gsel  = gcfg_r[E1RX_GSEL_MSB:0];
   assign xfi.phase = phase_r;
   assign xf_out    = xfi.dout;

   e1rx_slot_xform u_xf (
      .xf (xfi)
   );

   // Output stage: one cycle after the input byte
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         out_valid    <= 1'b0;
         out_ts       <= 5'h00;
         out_data     <= 8'h00;
         out_sig      <= 4'h0;
         out_gap_lsb  <= 1'b0;
         out_gap_full <= 1'b0;
      end
      else if (ce)
      begin
         out_valid <= ts_valid;
         if (ts_valid)
         begin
            out_ts   <= ts_num;
            out_data <= xf_out;
            // Trunk code only on slots that own a signaling register
            out_sig  <= (e1rx_is_voice(ts_num) && strk_r[ts_num][E1RX_SIGNALING_TRUNK_ENABLE_BIT])
                        ? strk_r[ts_num][3:0] : ts_sig; // RULE21
            // Gapping is off outside clock master mode to keep the clock whole
            out_gap_full <= rx_clk_master && gcfg_r[E1RX_GAP_EN_BIT]
                            && ctl_r[ts_num][E1RX_FULL_GAP]; // RULE18
            out_gap_lsb  <= rx_clk_master && gcfg_r[E1RX_GAP_EN_BIT]
                            && ctl_r[ts_num][E1RX_LSB_GAP]
                            && !ctl_r[ts_num][E1RX_FULL_GAP]; // RULE18
         end
      end
   end

   // Host read data, registered; unmapped offsets read zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         host_rdata  <= 8'h00;
         host_rvalid <= 1'b0;
      end
      else if (ce)
      begin
         host_rvalid <= host_rd;
         if (host_rd)
         begin
            case (host_addr)
               E1RX_SB_ACC_CTRL: host_rdata <= sb_ctl_r;
               E1RX_SB_ACC_DATA: host_rdata <= sb_dat_r;
               E1RX_PL_ACC_CTRL: host_rdata <= pl_ctl_r;
               E1RX_PL_ACC_DATA: host_rdata <= pl_dat_r;
               E1RX_GLOBAL_CFG:  host_rdata <= {4'h0, gcfg_r};
               default:          host_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Checks on the stream and register paths
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_extract_copy: assert property ( // RULE3
      ce && ts_valid && e1rx_is_voice(ts_num) && smf_aligned && sig_en_r[ts_num]
      |=> sig_nib_r[$past(ts_num)] == $past(ts_sig))
      else $error("nibble not extracted");

   a_no_extract_unsync: assert property ( // RULE2
      ce && ts_valid && !smf_aligned
      |=> sig_nib_r[$past(ts_num)] == $past(sig_nib_r[ts_num]))
      else $error("extract without alignment");

   a_pass_unchanged: assert property ( // RULE9
      ce && ts_valid && gcfg_r[2:0] == 3'h0 && ctl_r[ts_num][7:2] == 6'h00
      |=> out_valid && out_data == $past(ts_data))
      else $error("payload not passed");

   a_trunk_substitute: assert property ( // RULE9
      ce && ts_valid && gcfg_r[2:0] == 3'h0 && ctl_r[ts_num][7:2] == 6'h08
      |=> out_data == $past(dtrk_r[ts_num]))
      else $error("data trunk not substituted");

   a_global_wins: assert property ( // RULE8
      ce && ts_valid && gcfg_r[2:0] == 3'h1
      |=> out_data == ($past(dtrk_r[ts_num]) ^ $past(e1rx_inv_mask(ctl_r[ts_num]))))
      else $error("global select ignored");

   a_even_invert: assert property ( // RULE11
      ce && ts_valid && gcfg_r[2:0] == 3'h0 && ctl_r[ts_num][7:2] == 6'h01
      |=> out_data == ($past(ts_data) ^ 8'h55))
      else $error("even inversion wrong");

   a_all_invert: assert property ( // RULE17
      ce && ts_valid && gcfg_r[2:0] == 3'h0 && ctl_r[ts_num][7:2] == 6'h07
      |=> out_data == ~$past(ts_data))
      else $error("full inversion wrong");

   a_sig_trunk: assert property ( // RULE21
      ce && ts_valid && e1rx_is_voice(ts_num) && strk_r[ts_num][4]
      |=> out_sig == $past(strk_r[ts_num][3:0]))
      else $error("signaling trunk not applied");

   a_gap_gate: assert property ( // RULE18
      ce && ts_valid && !rx_clk_master |=> !out_gap_full && !out_gap_lsb)
      else $error("gap outside master mode");

   a_ind_write: assert property ( // RULE5
      pl_go && !rnw && ia[6:5] == 2'b00
      |=> ctl_r[$past(ia_ts)] == $past(pl_dat_r))
      else $error("indirect write lost");

   c_extract: cover property (ce && ts_valid && smf_aligned && sig_en_r[ts_num]);
   c_alaw: cover property (ce && ts_valid && xfi.gsel == E1RX_SEL_ALAW);
   c_ind_read: cover property (pl_go && rnw ##2 host_rd);
endmodule // e1rx_tsc_top
`default_nettype wire

/* dv/e1rx_framer_model.sv */
// Receive framer model: presents timeslot bytes to the conditioning block
`timescale 1ns/100ps
`default_nettype none
module e1rx_framer_model
(
   // Clock
   input  wire logic  clk,
   // Stream towards the block
   output logic       ts_valid,
   output logic [4:0] ts_num,
   output logic [7:0] ts_data,
   output logic [3:0] ts_sig
);
   // Idle stream at time zero
   initial
   begin
      ts_valid = 1'b0;
      ts_num   = 5'h00;
      ts_data  = 8'h00;
      ts_sig   = 4'h0;
   end

   // One byte for one cycle, then inverted lines so a stale byte never looks right
   task automatic put(input logic [4:0] n, input logic [7:0] d, input logic [3:0] s);
      @(negedge clk);
      ts_valid = 1'b1;
      ts_num   = n;
      ts_data  = d;
      ts_sig   = s;
      @(negedge clk);
      ts_valid = 1'b0;
      ts_data  = ~d;
      ts_sig   = ~s;
   endtask
endmodule // e1rx_framer_model
`default_nettype wire

/* dv/test_e1_rx_timeslot_conditioning.sv */
// Self-checking bench for the E1 receive timeslot conditioning block
`timescale 1ns/100ps
`default_nettype none
module test_e1_rx_timeslot_conditioning
   import e1rx_pkg::*;
();
   localparam int LIMIT = 20000;
   logic       clk, ce, rst_n, host_wr, host_rd, host_rvalid;
   logic [2:0] host_addr;
   logic [7:0] host_wdata, host_rdata, ts_data, out_data, v, gcfg;
   logic       ts_valid, smf_aligned, rx_clk_master, out_valid, out_gap_lsb, out_gap_full;
   logic [4:0] ts_num, out_ts;
   logic [3:0] ts_sig, out_sig;
   logic [6:0] a;
   logic [7:0] ctl [32];
   logic [7:0] dtrk [32];
   logic [7:0] strk [32];
   logic [7:0] inv_tab [8] = '{8'h00, 8'h55, 8'h2A, 8'h7F, 8'h80, 8'hD5, 8'hAA, 8'hFF};
   int         n_errors, n_compared, cycles, phase, f, i;

   e1rx_tsc_top u_dut (.clk(clk), .ce(ce), .rst_n(rst_n), .host_wr(host_wr),
      .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ts_valid(ts_valid),
      .ts_num(ts_num), .ts_data(ts_data), .ts_sig(ts_sig), .smf_aligned(smf_aligned),
      .rx_clk_master(rx_clk_master), .out_valid(out_valid), .out_ts(out_ts),
      .out_data(out_data), .out_sig(out_sig), .out_gap_lsb(out_gap_lsb),
      .out_gap_full(out_gap_full));
   e1rx_framer_model u_fr (.clk(clk), .ts_valid(ts_valid), .ts_num(ts_num),
      .ts_data(ts_data), .ts_sig(ts_sig));

   // Free-running 200 MHz clock
   always #2.5 clk = ~clk;

   // Hang guard: a stuck wait ends the run as a failure
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_errors++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("errors %0d, compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Direct write; strobe drops a cycle later so back-to-back calls never collide
   task automatic hw(input logic [2:0] ad, input logic [7:0] d);
      @(negedge clk);
      host_wr    = 1'b1;
      host_addr  = ad;
      host_wdata = d;
      @(negedge clk);
      host_wr    = 1'b0;
      if (ad == E1RX_GLOBAL_CFG)
         gcfg = d;
   endtask

   // Direct read; answer is a one-cycle pulse, so it is looked at right away
   task automatic hr(input logic [2:0] ad, output logic [7:0] d);
      @(negedge clk);
      host_rd   = 1'b1;
      host_addr = ad;
      @(negedge clk);
      host_rd   = 1'b0;
      check({7'h00, host_rvalid}, 8'h01);
      d = host_rdata;
   endtask

   // Indirect payload write, data first then address; shadows follow the map
   task automatic pw(input logic [6:0] ad, input logic [7:0] d);
      hw(E1RX_PL_ACC_DATA, d);
      hw(E1RX_PL_ACC_CTRL, {1'b0, ad});
      if (ad < 7'h20)
         ctl[ad[4:0]] = d;
      else if (ad < 7'h40)
         dtrk[ad[4:0]] = d;
      else if (ad < 7'h60 && ad[3:0] != 4'h0)
         strk[ad[4:0]] = d;
   endtask

   // Indirect read through either access pair
   task automatic ir(input logic [2:0] c, input logic [6:0] ad, output logic [7:0] d);
      hw(c, {1'b1, ad});
      hr(c + 3'h1, d);
   endtask

   // Expected payload: replacement first, then inversion
   function automatic logic [7:0] exp_data(input logic [7:0] d, input logic [4:0] n);
      logic [2:0] s;
      logic [7:0] r;
      s = (gcfg[2:0] != 3'h0) ? gcfg[2:0] : ctl[n][7:5];
      case (s)
         3'h1:    r = dtrk[n];
         3'h2:    r = E1RX_ALAW_MW[63 - 8 * phase -: 8];
         3'h3:    r = E1RX_ULAW_MW[63 - 8 * phase -: 8];
         default: r = d;
      endcase
      return r ^ {ctl[n][4], {3{ctl[n][2], ctl[n][3]}}, ctl[n][2]};
   endfunction

   // Send one byte and check every output it makes, out_gap_lsb only while full gap is clear
   task automatic send(input logic [4:0] n, input logic [7:0] d, input logic [3:0] s);
      logic g;
      u_fr.put(n, d, s);
      g = rx_clk_master & gcfg[E1RX_GAP_EN_BIT];
      check({7'h00, out_valid}, 8'h01);
      check({3'h0, out_ts}, {3'h0, n});
      check(out_data, exp_data(d, n));
      check({4'h0, out_sig}, {4'h0, (n[3:0] != 4'h0 && strk[n][4]) ? strk[n][3:0] : s});
      check({7'h00, out_gap_full}, {7'h00, g & ctl[n][0]});
      if (!ctl[n][0])
         check({7'h00, out_gap_lsb}, {7'h00, g & ctl[n][1]});
      if (n == 5'h1F)
         phase = (phase + 1) % 8;
   endtask

   // Main sequence
   initial
   begin
      clk = 1'b0; ce = 1'b1; rst_n = 1'b0; host_wr = 1'b0; host_rd = 1'b0;
      host_addr = 3'h0; host_wdata = 8'h00; smf_aligned = 1'b0; rx_clk_master = 1'b0;
      gcfg = 8'h00; phase = 0;
      for (i = 0; i < 32; i++)
      begin
         ctl[i] = 8'h00; dtrk[i] = 8'h00; strk[i] = 8'h00;
      end
      void'($urandom(98));
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      check({7'h00, out_valid}, 8'h00);
      check(out_data, 8'h00);
      hw(3'h5, 8'hFF);
      hr(3'h5, v);
      check(v, 8'h00);
      // Fixed inversion table on slot 2 with an all-zero byte
      for (i = 0; i < 8; i++)
      begin
         pw(7'h02, {3'h0, 3'(i), 2'b00});
         send(5'h02, 8'h00, 4'h0);
         check(out_data, inv_tab[i]);
      end
      // Random frames; ten frames wrap the milliwatt phase
      for (f = 0; f < 10; f++)
      begin
         for (i = 0; i < 4; i++)
         begin
            pw({2'b00, 5'($urandom)}, 8'($urandom));
            pw({2'b01, 5'($urandom)}, 8'($urandom));
            pw({2'b10, 5'($urandom)}, 8'($urandom) & 8'h5F);
         end
         hw(E1RX_GLOBAL_CFG, {4'h0, 1'($urandom), ($urandom % 3 == 0) ? 3'($urandom) : 3'h0});
         rx_clk_master = 1'($urandom);
         for (i = 0; i < 32; i++)
            send(5'(i), 8'($urandom), 4'($urandom));
      end
      // Register readback across the whole indirect space
      for (i = 0; i < 40; i++)
      begin
         a = 7'($urandom);
         ir(E1RX_PL_ACC_CTRL, a, v);
         if (a < 7'h20)
            check(v, ctl[a[4:0]]);
         else if (a < 7'h40)
            check(v, dtrk[a[4:0]]);
         else if (a < 7'h60 && a[3:0] != 4'h0)
            check(v, strk[a[4:0]]);
         else
            check(v, 8'h00);
      end
      // Clock enable low: host write, byte and frame phase must all stay frozen
      hw(E1RX_GLOBAL_CFG, 8'h00);
      ce = 1'b0;
      hw(E1RX_GLOBAL_CFG, 8'h0F);
      u_fr.put(5'h1F, 8'hA5, 4'h3);
      check({7'h00, out_valid}, 8'h00);
      ce = 1'b1;
      gcfg = 8'h00;
      hr(E1RX_GLOBAL_CFG, v);
      check(v, 8'h00);
      // Signaling extraction on slot 5, then unmapped buffer address 10 and the reserved bits of slot 1F
      smf_aligned = 1'b1;
      hw(E1RX_SB_ACC_DATA, 8'h10);
      hw(E1RX_SB_ACC_CTRL, 8'h05);
      send(5'h05, 8'h3C, 4'hA);
      ir(E1RX_SB_ACC_CTRL, 7'h05, v);
      check(v, 8'h1A);
      smf_aligned = 1'b0;
      send(5'h05, 8'h3C, 4'h5);
      ir(E1RX_SB_ACC_CTRL, 7'h05, v);
      check(v, 8'h1A);
      hw(E1RX_SB_ACC_DATA, 8'h1F);
      hw(E1RX_SB_ACC_CTRL, 8'h05);
      ir(E1RX_SB_ACC_CTRL, 7'h05, v);
      check(v, 8'h1A);
      smf_aligned = 1'b1;
      hw(E1RX_SB_ACC_DATA, 8'h00);
      hw(E1RX_SB_ACC_CTRL, 8'h05);
      send(5'h05, 8'h3C, 4'h6);
      ir(E1RX_SB_ACC_CTRL, 7'h05, v);
      check(v & 8'hF0, 8'h00);
      hw(E1RX_SB_ACC_DATA, 8'h1F);
      hw(E1RX_SB_ACC_CTRL, 8'h10);
      ir(E1RX_SB_ACC_CTRL, 7'h10, v);
      check(v, 8'h00);
      ir(E1RX_SB_ACC_CTRL, 7'h1F, v);
      check(v & 8'hE0, 8'h00);
      complete_run();
   end
endmodule // test_e1_rx_timeslot_conditioning
`default_nettype wire
